// ### rtl/sodc_link.sv
// Purpose: serial shifter on the link clock
// Assumes: link clock stands still while select is high
// Notes: word is taken over without a handshake once the system side sees the synchronised select rise
`timescale 1ns/1ps
`default_nettype none
module sodc_link
(
	// link
	input  wire logic              link_clk,
	input  wire logic              select_low,
	input  wire logic              mosi,
	// to system side
	output var sodc_pkg::sodc_link_s link
);
	sodc_pkg::sodc_link_s st;
	sodc_pkg::sodc_link_s next_st;
	logic                 armed;

	// count of the last frame must survive select high until the system side
	// takes it, so the restart is deferred to the first edge of the next frame
	always_comb
	begin
		next_st = st;
		if (!select_low)
		begin
			next_st.shift = {st.shift[sodc_pkg::WORD_BITS-2:0], mosi};
			if (armed)
				next_st.count = sodc_pkg::CNT_ONE;
			else if (st.count != sodc_pkg::CNT_FULL)
				next_st.count = st.count + sodc_pkg::CNT_ONE;
		end
	end

	always_ff @(posedge link_clk)
	begin
		st <= next_st;
	end

	// set while deselected, cleared by the first link edge of a frame
	always_ff @(posedge link_clk or posedge select_low)
	begin
		if (select_low)
			armed <= 1'b1;
		else
			armed <= 1'b0;
	end

	assign link = st;
endmodule
`default_nettype wire

// ### rtl/sodc_pkg.sv
// Purpose: shared constants and types for the serial output driver control block
// Assumes: system clock 40 MHz, link clock from the serial master
// Notes: one write-only 8-bit register, no address
package sodc_pkg;
	localparam int          WORD_BITS      = 8;
	localparam int          CNT_BITS       = 4;
	localparam logic [7:0]  SWITCH_RESET   = 8'h00;
	localparam logic [3:0]  CNT_ZERO       = 4'h0;
	localparam logic [3:0]  CNT_ONE        = 4'h1;
	localparam logic [3:0]  CNT_FULL       = 4'h8;
	localparam int          FIRST_OUT_BIT  = 0;
	localparam int          SYS_CLK_MHZ    = 40;
	localparam int          GAP_NS         = 170;
	localparam int          GAP_CYCLES     = (GAP_NS * SYS_CLK_MHZ + 999) / 1000;

	typedef struct packed {
		logic [7:0] word;
		logic       tog;
	} sodc_word_s;

	typedef struct packed {
		logic [7:0] shift;
		logic [3:0] count;
	} sodc_link_s;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_LOAD = 2'b10
	} sodc_state_e;
endpackage

// ### rtl/sodc_sync.sv
// Purpose: two-flop synchroniser for one level
// Assumes: input from another clock domain or a pin
// Notes: first flop is read only by the second
`timescale 1ns/1ps
`default_nettype none
module sodc_sync
#(
	parameter logic INIT = 1'b0
)
(
	// clocking
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	// level
	input  wire logic d,
	output var  logic q
);
	typedef struct packed {
		logic meta;
		logic q;
	} sodc_sync_s;

	sodc_sync_s st;
	sodc_sync_s next_st;

	always_comb
	begin
		next_st = st;
		if (ce)
		begin
			next_st.meta = d;
			next_st.q    = st.meta;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			st <= {INIT, INIT}; // idle level of the pin, so no false edge after reset
		else
			st <= next_st;
	end

	assign q = st.q;
endmodule
`default_nettype wire

// ### rtl/sodc_top.sv
// Functional notes
// - each transfer carries one 8-bit word on the master's serial clock
// - one 8-bit register; bit 0 drives output 1, bit 7 output 8
// - bit 0 is off, 1 is on; all bits reset to 0
// - clock and data are ignored while select is high
// - select rise copies shifted word into the register on the 4th SYS_CLK edge after it (synchroniser, held copy, load)
// - force-enable high turns output 1 on regardless of its bit
//
// Purpose: serial control port loading an 8-bit low-side switch register
// Assumes: SYS_CLK 40 MHz, link clock from the master, idle low
// Notes: a word shorter than 8 clocks is discarded
`timescale 1ns/1ps
`default_nettype none
module sodc_top
(
	// system
	input  wire logic       SYS_CLK,
	input  wire logic       RESET,
	input  wire logic       CLK_EN,
	// serial link
	input  wire logic       LINK_CLK,
	input  wire logic       SELECT_LOW,
	input  wire logic       MOSI,
	// force pin
	input  wire logic       FIRST_LOW_SIDE_OUTPUT_FORCE_ENABLE,
	// drivers
	output var  logic [7:0] LOW_SIDE_OUTPUT
);
	typedef struct packed {
		sodc_pkg::sodc_state_e state;
		logic                  sel_d;
		logic [7:0]            held;
		logic [7:0]            output_switch_control;
		logic [7:0]            drive;
	} sodc_top_s;

	sodc_top_s            st;
	sodc_top_s            next_st;
	sodc_pkg::sodc_link_s link;
	logic                 sel_s;
	logic                 force_s;

	sodc_link u_link
	(
		.link_clk   (LINK_CLK),
		.select_low (SELECT_LOW),
		.mosi       (MOSI),
		.link       (link)
	);

	sodc_sync
	#(
		.INIT (1'b1)
	)
	u_sync_sel
	(
		.clk (SYS_CLK),
		.rst (RESET),
		.ce  (CLK_EN),
		.d   (SELECT_LOW),
		.q   (sel_s)
	);

	sodc_sync u_sync_force
	(
		.clk (SYS_CLK),
		.rst (RESET),
		.ce  (CLK_EN),
		.d   (FIRST_LOW_SIDE_OUTPUT_FORCE_ENABLE),
		.q   (force_s)
	);

	// link word is frozen while select is high (no link edges), so it is
	// stable by the time the synchronised rise is seen: a handshake-free take-over
	always_comb
	begin
		next_st = st;
		next_st.sel_d = sel_s;
		next_st.state = sodc_pkg::ST_IDLE;
		case (st.state)
			sodc_pkg::ST_IDLE:
			begin
				if (sel_s && !st.sel_d && link.count == sodc_pkg::CNT_FULL)
				begin
					next_st.held  = link.shift;
					next_st.state = sodc_pkg::ST_LOAD;
				end
			end
			sodc_pkg::ST_LOAD:
			begin
				next_st.output_switch_control = st.held;
				next_st.state = sodc_pkg::ST_IDLE;
			end
			default:
				next_st.state = sodc_pkg::ST_IDLE;
		endcase
		next_st.drive = st.output_switch_control;
		if (force_s)
			next_st.drive[sodc_pkg::FIRST_OUT_BIT] = 1'b1;
		if (!CLK_EN)
			next_st = st;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			st.state                 <= sodc_pkg::ST_IDLE;
			st.sel_d                 <= 1'b1;
			st.held                  <= sodc_pkg::SWITCH_RESET;
			st.output_switch_control <= sodc_pkg::SWITCH_RESET;
			st.drive                 <= sodc_pkg::SWITCH_RESET;
		end
		else
			st <= next_st;
	end

	assign LOW_SIDE_OUTPUT = st.drive;

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RESET || !CLK_EN);

	a_force_first_on: assert property (force_s |=> LOW_SIDE_OUTPUT[0])
		else $error("output 1 not forced on");
	a_reg_drives_out: assert property ($changed(st.output_switch_control) |=>
		LOW_SIDE_OUTPUT[7:1] == $past(st.output_switch_control[7:1]) || !CLK_EN)
		else $error("outputs do not follow register");
	a_load_on_rise: assert property ((st.state == sodc_pkg::ST_LOAD) |=>
		st.output_switch_control == $past(st.held))
		else $error("register not loaded after select rise");
	a_full_word_only: assert property ((sel_s && !st.sel_d && link.count != sodc_pkg::CNT_FULL)
		|=> st.state == sodc_pkg::ST_IDLE)
		else $error("short word accepted");
	a_stable_no_load: assert property ((st.state == sodc_pkg::ST_IDLE) |=>
		$stable(st.output_switch_control))
		else $error("register changed without a load");
	a_no_force_follow: assert property (!force_s && $stable(st.output_switch_control) |=>
		LOW_SIDE_OUTPUT[0] == $past(st.output_switch_control[0]))
		else $error("output 1 does not follow its bit");
	a_load_one_cycle: assert property ((st.state == sodc_pkg::ST_LOAD) |=>
		st.state == sodc_pkg::ST_IDLE)
		else $error("load state held");
	a_out_latency: assert property ((st.state == sodc_pkg::ST_LOAD) ##1 !force_s |=>
		LOW_SIDE_OUTPUT == $past(st.output_switch_control))
		else $error("outputs not updated together");

	c_word_loaded: cover property (st.state == sodc_pkg::ST_LOAD);
	c_forced: cover property (force_s && !st.output_switch_control[0]);
	c_two_words: cover property (st.state == sodc_pkg::ST_LOAD ##[2:200]
		st.state == sodc_pkg::ST_LOAD);
endmodule
`default_nettype wire

// ### verif/sodc_master.sv
// Purpose: serial master model for the control link
// Assumes: link clock half period 6 ns
// Notes: clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module sodc_master
(
	// link
	output var logic link_clk,
	output var logic select_low,
	output var logic mosi
);
	initial
	begin
		link_clk   = 1'b0;
		select_low = 1'b1;
		mosi       = 1'b0;
	end

	// n below 8 makes a short, refused frame
	task automatic send(input logic [7:0] w, input int n);
		select_low = 1'b0;
		#83;
		for (int i = n - 1; i >= 0; i--)
		begin
			mosi = w[i];
			#6 link_clk = 1'b1;
			#6 link_clk = 1'b0;
		end
		#80 select_low = 1'b1;
		mosi = ~mosi; // undriven line must not keep the last bit
		#180;
	endtask
endmodule
`default_nettype wire

// ### verif/sodc_top_tb.sv
// Purpose: self-checking bench for the switch register port
// Assumes: SYS_CLK 25 ns, link from sodc_master
// Notes: fixed waits follow the five-edge answer latency
`timescale 1ns/1ps
`default_nettype none
module sodc_top_tb;
	logic       sys_clk;
	logic       reset;
	logic       clk_en;
	logic       force_en;
	wire        link_clk;
	wire        select_low;
	wire        mosi;
	logic [7:0] outs;
	int         num_errors = 0;
	int         total_checks = 0;

	sodc_master MST
	(
		.link_clk   (link_clk),
		.select_low (select_low),
		.mosi       (mosi)
	);

	sodc_top DUT
	(
		.SYS_CLK           (sys_clk),
		.RESET             (reset),
		.CLK_EN            (clk_en),
		.LINK_CLK          (link_clk),
		.SELECT_LOW        (select_low),
		.MOSI              (mosi),
		.FIRST_LOW_SIDE_OUTPUT_FORCE_ENABLE (force_en),
		.LOW_SIDE_OUTPUT   (outs)
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// answer lands 5 edges after select rise, inside the 180 ns tail of send; 9 more leave margin
	task automatic load(input logic [7:0] w, input int n, input logic [7:0] e);
		MST.send(w, n);
		wait_clk(9);
		chk("outputs", e, outs);
	endtask

	initial
	begin
		#1000000;
		num_errors++;
		final_report();
	end

	initial
	begin
		reset    = 1'b1;
		clk_en   = 1'b1;
		force_en = 1'b0;
		wait_clk(6);
		chk("reset value", 8'h00, outs);
		reset = 1'b0;
		wait_clk(4);
		load(8'hA5, 8, 8'hA5);
		for (int i = 0; i < 8; i++)
			load(8'h01 << i, 8, 8'h01 << i);
		load(8'h5A, 8, 8'h5A);
		load(8'h00, 7, 8'h5A);
		force_en = 1'b1;
		wait_clk(4);
		chk("forced", 8'h5B, outs);
		force_en = 1'b0;
		wait_clk(4);
		chk("released", 8'h5A, outs);
		MST.send(8'h81, 8);
		load(8'h7E, 8, 8'h7E);
		clk_en = 1'b0;
		load(8'hC3, 8, 8'h7E);
		clk_en = 1'b1;
		wait_clk(9);
		chk("resumed", 8'h7E, outs);
		load(8'hC3, 8, 8'hC3);
		repeat (2)
		begin
			load(8'h01, 8, 8'h01);
			#100000;
			load(8'h00, 8, 8'h00);
			#100000;
		end
		reset = 1'b1;
		wait_clk(2);
		chk("second reset", 8'h00, outs);
		reset = 1'b0;
		wait_clk(4);
		load(8'hFF, 8, 8'hFF);
		final_report();
	end
endmodule
`default_nettype wire
